// file: src/tcc_pkg.sv
// constants, field layouts and carrier types of the timer capture/compare unit
// assumes an apb master with 32-bit data; registers sit on byte lanes [7:0]
package tcc_pkg;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 12;
  localparam int DIV_12 = 12;
  localparam int DIV_24 = 24;
  localparam int DIV_W = 5;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'hc8;
  localparam logic [7:0] IDX_FUNC = 8'hc1;
  localparam logic [7:0] IDX_CNT_HI = 8'hcd;
  localparam logic [7:0] IDX_CNT_LO = 8'hcc;
  localparam logic [7:0] IDX_INTEN_PRI = 8'ha8;
  localparam logic [7:0] IDX_INTEN_SEC = 8'hb8;
  localparam logic [7:0] IDX_FLAGS = 8'hc0;
  localparam logic [7:0] IDX_LEVEL = 8'hc9;
  // module low and high byte indexes, module 0 in the lowest byte
  localparam logic [31:0] CC_LO_IDX = 32'hc6c4c2ca;
  localparam logic [31:0] CC_HI_IDX = 32'hc7c5c3cb;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [31:0] RD_ZERO = 32'h00000000;
  localparam logic [1:0] CLK_STOP = 2'b00;
  localparam logic [1:0] CLK_CPU = 2'b01;
  localparam logic [1:0] CLK_PIN = 2'b10;
  localparam logic [1:0] CLK_GATED = 2'b11;
  localparam logic [1:0] RL_OVF = 2'b10;
  localparam logic [1:0] RL_PIN = 2'b11;
  localparam logic [1:0] FN_OFF = 2'b00;
  localparam logic [1:0] FN_CAP_PIN = 2'b01;
  localparam logic [1:0] FN_CMP = 2'b10;
  localparam logic [1:0] FN_CAP_WR = 2'b11;
  localparam int INTEN_PRI_GLOBAL_BIT = 7;
  localparam int INTEN_PRI_TIMER_BIT = 5;
  localparam int INTEN_SEC_RELOAD_BIT = 7;
  localparam int INTEN_SEC_CMP_LSB = 2;
  localparam int FLG_RELOAD_BIT = 7;
  localparam int FLG_OVF_BIT = 6;
  localparam int FLG_CMP_LSB = 2;

  typedef struct packed {
    logic prescaleSelect;
    logic edgeOrMatchSelect;
    logic spare;
    logic [1:0] reloadSelectField;
    logic compareMethodSelect;
    logic [1:0] clockControlField;
  } tcc_ctrl_t;

  typedef struct packed {
    logic countInputPin;
    logic reloadPin;
    logic [3:0] captureInputPin;
  } tcc_pins_t;

  localparam tcc_ctrl_t CTRL_RST = '0;

  function automatic logic tcc_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction
endpackage

// file: src/tcc_timer_unit.sv
// timer capture/compare unit: 16-bit counter, four capture/compare modules
// assumes pins synchronous-ish single-bit levels and an apb master on clock
// registers sit on byte lane [7:0]; upper read bits are always zero
`timescale 1ns/10ps
module tcc_timer_unit #(
  parameter int DIV_FAST = tcc_pkg::DIV_12,
  parameter int DIV_SLOW = tcc_pkg::DIV_24
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tcc_pkg::tcc_pins_t pinsIn,
  output logic [tcc_pkg::NUM_CH-1:0] compareOut,
  output logic [tcc_pkg::NUM_CH-1:0] compareOutEnable,
  output logic timerIrq
);
  localparam int NCH = tcc_pkg::NUM_CH;

  tcc_pkg::tcc_ctrl_t ctrl_reg, ctrl_next;
  logic [7:0] funcSel_reg, funcSel_next;
  logic [15:0] count_reg, count_next;
  logic [15:0] cc_reg [NCH];
  logic [15:0] cc_next [NCH];
  logic globalEn_reg, globalEn_next;
  logic timerEn_reg, timerEn_next;
  logic reloadEn_reg, reloadEn_next;
  logic [NCH-1:0] cmpEn_reg, cmpEn_next;
  logic ovfFlag_reg, ovfFlag_next;
  logic rlFlag_reg, rlFlag_next;
  logic [NCH-1:0] cmpFlag_reg, cmpFlag_next;
  logic [NCH-1:0] level_reg, level_next;
  logic [tcc_pkg::DIV_W-1:0] div_reg, div_next;
  tcc_pkg::tcc_pins_t pinS1_reg, pinS2_reg, pinPrev_reg;
  logic [NCH-1:0] matchPrev_reg, matchPrev_next;
  logic [NCH-1:0] cmpOut_reg, cmpOut_next;
  logic [NCH-1:0] cmpOutEn_reg, cmpOutEn_next;
  logic irq_reg, irq_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;

  logic setup, wrEn;
  logic [7:0] wd;
  logic [tcc_pkg::DIV_W-1:0] divLast;
  logic divRun, tick, ovf, rlEvt;
  logic cntFall, rlFall;
  logic [NCH-1:0] capRise, capFall;
  logic [NCH-1:0] matchNow, cmpEvt;
  logic [1:0] fn;
  logic mapped;
  logic timerReq, cmpReq;

  function automatic logic wrHit(input logic en, input logic [tcc_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] idx);
    return en && tcc_pkg::tcc_hit(a, idx);
  endfunction

  always_comb begin
    ctrl_next = ctrl_reg;
    funcSel_next = funcSel_reg;
    count_next = count_reg;
    globalEn_next = globalEn_reg;
    timerEn_next = timerEn_reg;
    reloadEn_next = reloadEn_reg;
    cmpEn_next = cmpEn_reg;
    level_next = level_reg;
    div_next = div_reg;
    matchPrev_next = matchPrev_reg;
    cmpOut_next = cmpOut_reg;
    cmpOutEn_next = cmpOutEn_reg;
    prdata_next = prdata_reg;
    mapped = 1'b1;
    fn = tcc_pkg::FN_OFF;
    for (int i = 0; i < NCH; i++) begin
      cc_next[i] = cc_reg[i];
    end

    // bus: answer is prepared in setup, so pready rises in the first access cycle
    setup = psel && !penable;
    wrEn = psel && penable && pwrite && pready_reg;
    wd = pwdata[7:0];
    pready_next = setup;
    pslverr_next = pslverr_reg;

    // edges from second stage against previous sample; first stage untouched
    cntFall = pinPrev_reg.countInputPin && !pinS2_reg.countInputPin;
    rlFall = pinPrev_reg.reloadPin && !pinS2_reg.reloadPin;
    capRise = ~pinPrev_reg.captureInputPin & pinS2_reg.captureInputPin;
    capFall = pinPrev_reg.captureInputPin & ~pinS2_reg.captureInputPin;

    // prescaler; gated mode freezes it so the pause is exact
    // limitation: phase is kept across a stop, so the first tick may come early
    divLast = ctrl_reg.prescaleSelect ? tcc_pkg::DIV_W'(DIV_SLOW - 1) :
              tcc_pkg::DIV_W'(DIV_FAST - 1);
    divRun = 1'b0;
    tick = 1'b0;
    case (ctrl_reg.clockControlField)
      tcc_pkg::CLK_CPU: begin
        divRun = 1'b1;
      end
      tcc_pkg::CLK_GATED: begin
        divRun = pinS2_reg.countInputPin;
      end
      tcc_pkg::CLK_PIN: begin
        tick = cntFall;
      end
      tcc_pkg::CLK_STOP: begin
        divRun = 1'b0;
      end
      default: begin
        divRun = 1'b0;
      end
    endcase
    if (divRun) begin
      if (div_reg == divLast) begin
        div_next = '0;
        tick = 1'b1;
      end else begin
        div_next = div_reg + tcc_pkg::DIV_W'(1);
      end
    end

    // counter
    ovf = 1'b0;
    rlEvt = 1'b0;
    if (tick) begin
      if (count_reg == tcc_pkg::CNT_MAX) begin
        ovf = 1'b1;
        if (ctrl_reg.reloadSelectField == tcc_pkg::RL_OVF) begin
          count_next = cc_reg[0];
        end else begin
          count_next = tcc_pkg::RST_WORD;
        end
      end else begin
        count_next = count_reg + tcc_pkg::CNT_ONE;
      end
    end
    if (ctrl_reg.reloadSelectField == tcc_pkg::RL_PIN && rlFall) begin
      count_next = cc_reg[0];
      rlEvt = 1'b1;
    end
    // software write to the counter bytes wins over counting
    if (wrHit(wrEn, paddr, tcc_pkg::IDX_CNT_LO)) begin
      count_next[7:0] = wd;
    end
    if (wrHit(wrEn, paddr, tcc_pkg::IDX_CNT_HI)) begin
      count_next[15:8] = wd;
    end

    // modules
    for (int i = 0; i < NCH; i++) begin
      fn = funcSel_reg[2*i +: 2];
      matchNow[i] = (count_reg == cc_reg[i]);
      cmpEvt[i] = 1'b0;
      // pin owned whenever the module is enabled, in any function
      cmpOutEn_next[i] = (fn != tcc_pkg::FN_OFF);
      if (fn == tcc_pkg::FN_CMP) begin
        matchPrev_next[i] = matchNow[i];
        if (i == 0 && !ctrl_reg.edgeOrMatchSelect) begin
          cmpEvt[i] = !matchNow[i] && matchPrev_reg[i];
        end else begin
          cmpEvt[i] = matchNow[i] && !matchPrev_reg[i];
        end
        if (!ctrl_reg.compareMethodSelect) begin
          cmpOut_next[i] = (count_reg >= cc_reg[i]);
        end else if (matchNow[i] && !matchPrev_reg[i]) begin
          // only a fresh match moves the pin, never a wrap
          cmpOut_next[i] = level_reg[i];
        end
      end else begin
        matchPrev_next[i] = 1'b0;
        cmpOut_next[i] = 1'b0;
      end
      if (wrHit(wrEn, paddr, tcc_pkg::CC_HI_IDX[8*i +: 8])) begin
        cc_next[i][15:8] = wd;
      end
      if (wrHit(wrEn, paddr, tcc_pkg::CC_LO_IDX[8*i +: 8])) begin
        if (fn == tcc_pkg::FN_CAP_WR) begin
          cc_next[i] = count_reg;
        end else begin
          cc_next[i][7:0] = wd;
        end
      end
      // pin capture last, so it beats a same-cycle write to the register
      if (fn == tcc_pkg::FN_CAP_PIN) begin
        if (i == 0 && !ctrl_reg.edgeOrMatchSelect) begin
          if (capFall[i]) begin
            cc_next[i] = count_reg;
          end
        end else if (capRise[i]) begin
          cc_next[i] = count_reg;
        end
      end
    end

    // flags: a hardware set in the same cycle beats a software clear
    ovfFlag_next = ovfFlag_reg;
    rlFlag_next = rlFlag_reg;
    cmpFlag_next = cmpFlag_reg;
    if (wrHit(wrEn, paddr, tcc_pkg::IDX_FLAGS)) begin
      ovfFlag_next = wd[tcc_pkg::FLG_OVF_BIT];
      rlFlag_next = wd[tcc_pkg::FLG_RELOAD_BIT];
      cmpFlag_next = wd[tcc_pkg::FLG_CMP_LSB +: NCH];
    end
    ovfFlag_next = ovfFlag_next | ovf;
    // without both enables a pin edge still reloads, but leaves no flag
    rlFlag_next = rlFlag_next | (rlEvt && reloadEn_reg && timerEn_reg);
    cmpFlag_next = cmpFlag_next | cmpEvt;

    // shared request line; firmware sorts the events by the flags
    timerReq = timerEn_reg && (ovfFlag_reg || rlFlag_reg);
    cmpReq = |(cmpFlag_reg & cmpEn_reg);
    irq_next = globalEn_reg && (timerReq || cmpReq);

    // control writes
    if (wrHit(wrEn, paddr, tcc_pkg::IDX_CTRL)) begin
      ctrl_next = tcc_pkg::tcc_ctrl_t'(wd);
    end
    if (wrHit(wrEn, paddr, tcc_pkg::IDX_FUNC)) begin
      funcSel_next = wd;
    end
    if (wrHit(wrEn, paddr, tcc_pkg::IDX_INTEN_PRI)) begin
      globalEn_next = wd[tcc_pkg::INTEN_PRI_GLOBAL_BIT];
      timerEn_next = wd[tcc_pkg::INTEN_PRI_TIMER_BIT];
    end
    if (wrHit(wrEn, paddr, tcc_pkg::IDX_INTEN_SEC)) begin
      reloadEn_next = wd[tcc_pkg::INTEN_SEC_RELOAD_BIT];
      cmpEn_next = wd[tcc_pkg::INTEN_SEC_CMP_LSB +: NCH];
    end
    if (wrHit(wrEn, paddr, tcc_pkg::IDX_LEVEL)) begin
      level_next = wd[NCH-1:0];
    end

    // read data and error are fixed in setup and stand through access
    // limitation: no snapshot, so a running count may carry between byte reads
    if (setup) begin
      prdata_next = tcc_pkg::RD_ZERO;
      if (tcc_pkg::tcc_hit(paddr, tcc_pkg::IDX_CTRL)) begin
        prdata_next[7:0] = ctrl_reg;
      end else if (tcc_pkg::tcc_hit(paddr, tcc_pkg::IDX_FUNC)) begin
        prdata_next[7:0] = funcSel_reg;
      end else if (tcc_pkg::tcc_hit(paddr, tcc_pkg::IDX_CNT_LO)) begin
        prdata_next[7:0] = count_reg[7:0];
      end else if (tcc_pkg::tcc_hit(paddr, tcc_pkg::IDX_CNT_HI)) begin
        prdata_next[7:0] = count_reg[15:8];
      end else if (tcc_pkg::tcc_hit(paddr, tcc_pkg::IDX_INTEN_PRI)) begin
        prdata_next[tcc_pkg::INTEN_PRI_GLOBAL_BIT] = globalEn_reg;
        prdata_next[tcc_pkg::INTEN_PRI_TIMER_BIT] = timerEn_reg;
      end else if (tcc_pkg::tcc_hit(paddr, tcc_pkg::IDX_INTEN_SEC)) begin
        prdata_next[tcc_pkg::INTEN_SEC_RELOAD_BIT] = reloadEn_reg;
        prdata_next[tcc_pkg::INTEN_SEC_CMP_LSB +: NCH] = cmpEn_reg;
      end else if (tcc_pkg::tcc_hit(paddr, tcc_pkg::IDX_FLAGS)) begin
        prdata_next[tcc_pkg::FLG_RELOAD_BIT] = rlFlag_reg;
        prdata_next[tcc_pkg::FLG_OVF_BIT] = ovfFlag_reg;
        prdata_next[tcc_pkg::FLG_CMP_LSB +: NCH] = cmpFlag_reg;
      end else if (tcc_pkg::tcc_hit(paddr, tcc_pkg::IDX_LEVEL)) begin
        prdata_next[NCH-1:0] = level_reg;
      end else begin
        mapped = 1'b0;
        for (int i = 0; i < NCH; i++) begin
          if (tcc_pkg::tcc_hit(paddr, tcc_pkg::CC_LO_IDX[8*i +: 8])) begin
            prdata_next[7:0] = cc_reg[i][7:0];
            mapped = 1'b1;
          end
          if (tcc_pkg::tcc_hit(paddr, tcc_pkg::CC_HI_IDX[8*i +: 8])) begin
            prdata_next[7:0] = cc_reg[i][15:8];
            mapped = 1'b1;
          end
        end
      end
      pslverr_next = !mapped;
    end else if (!psel) begin
      pslverr_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= tcc_pkg::CTRL_RST;
      funcSel_reg <= tcc_pkg::RST_BYTE;
      count_reg <= tcc_pkg::RST_WORD;
      for (int i = 0; i < NCH; i++) begin
        cc_reg[i] <= tcc_pkg::RST_WORD;
      end
      globalEn_reg <= 1'b0;
      timerEn_reg <= 1'b0;
      reloadEn_reg <= 1'b0;
      cmpEn_reg <= '0;
      ovfFlag_reg <= 1'b0;
      rlFlag_reg <= 1'b0;
      cmpFlag_reg <= '0;
      level_reg <= '0;
      div_reg <= '0;
      pinS1_reg <= '0;
      pinS2_reg <= '0;
      pinPrev_reg <= '0;
      matchPrev_reg <= '0;
      cmpOut_reg <= '0;
      cmpOutEn_reg <= '0;
      irq_reg <= 1'b0;
      prdata_reg <= tcc_pkg::RD_ZERO;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      funcSel_reg <= funcSel_next;
      count_reg <= count_next;
      for (int i = 0; i < NCH; i++) begin
        cc_reg[i] <= cc_next[i];
      end
      globalEn_reg <= globalEn_next;
      timerEn_reg <= timerEn_next;
      reloadEn_reg <= reloadEn_next;
      cmpEn_reg <= cmpEn_next;
      ovfFlag_reg <= ovfFlag_next;
      rlFlag_reg <= rlFlag_next;
      cmpFlag_reg <= cmpFlag_next;
      level_reg <= level_next;
      div_reg <= div_next;
      // two-flop synchroniser; only the second stage feeds the edge logic
      pinS1_reg <= pinsIn;
      pinS2_reg <= pinS1_reg;
      pinPrev_reg <= pinS2_reg;
      matchPrev_reg <= matchPrev_next;
      cmpOut_reg <= cmpOut_next;
      cmpOutEn_reg <= cmpOutEn_next;
      irq_reg <= irq_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign compareOut = cmpOut_reg;
  assign compareOutEnable = cmpOutEn_reg;
  assign timerIrq = irq_reg;
endmodule

// file: sim/tcc_timer_unit_properties.sv
// port checker for the timer unit: apb timing, pin ownership, irq gating
// bound onto tcc_timer_unit from the bench top file
`timescale 1ns/10ps
module tcc_timer_unit_properties (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [tcc_pkg::NUM_CH-1:0] compareOut,
  input wire logic [tcc_pkg::NUM_CH-1:0] compareOutEnable,
  input wire logic timerIrq
);
  logic wrDone;
  logic [7:0] func_reg, func_next;
  logic glob_reg, glob_next;
  logic [3:0] ownExp, cmpExp;
  assign wrDone = psel && penable && pwrite && pready && !pslverr;
  // shadow of function field and global enable, tracked from bus writes
  always_comb begin
    func_next = func_reg;
    glob_next = glob_reg;
    if (wrDone && paddr == {2'b00, tcc_pkg::IDX_FUNC, 2'b00}) begin
      func_next = pwdata[7:0];
    end
    if (wrDone && paddr == {2'b00, tcc_pkg::IDX_INTEN_PRI, 2'b00}) begin
      glob_next = pwdata[tcc_pkg::INTEN_PRI_GLOBAL_BIT];
    end
    for (int i = 0; i < 4; i++) begin
      ownExp[i] = func_reg[2*i +: 2] != tcc_pkg::FN_OFF;
      cmpExp[i] = func_reg[2*i +: 2] == tcc_pkg::FN_CMP;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      func_reg <= 8'h00;
      glob_reg <= 1'b0;
    end else begin
      func_reg <= func_next;
      glob_reg <= glob_next;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // one cycle of slack after any write: outputs are registered
  property p_ready; psel && !penable |=> pready; endproperty
  property p_ready_once; pready |=> !pready; endproperty
  property p_upper; pready |-> prdata[31:8] == 24'h000000; endproperty
  property p_err_data; pready && pslverr && !pwrite |-> prdata == tcc_pkg::RD_ZERO; endproperty
  property p_misalign; psel && !penable && paddr[1:0] != 2'b00 |=> pready && pslverr; endproperty
  property p_owner; !$past(wrDone) |-> compareOutEnable == ownExp; endproperty
  property p_cmp_only; !$past(wrDone) |-> (compareOut & ~cmpExp) == 4'h0; endproperty
  property p_irq_gate; timerIrq && !$past(wrDone) |-> glob_reg; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_ready_once: assert property (p_ready_once) else $error("ready longer than one cycle");
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  a_err_data: assert property (p_err_data) else $error("error read data not zero");
  a_misalign: assert property (p_misalign) else $error("misaligned access not refused");
  a_owner: assert property (p_owner) else $error("pin ownership wrong");
  a_cmp_only: assert property (p_cmp_only) else $error("pin driven outside compare");
  a_irq_gate: assert property (p_irq_gate) else $error("request without global");
  c_irq: cover property (timerIrq);
  c_err: cover property (pready && pslverr);
  c_pin: cover property ($rose(compareOut[1]));
endmodule

// file: sim/tcc_pin_model.sv
// external pin sources: count, reload and four capture pins
// bench calls its tasks right after a rising edge
`timescale 1ns/10ps
module tcc_pin_model (
  input wire logic clock,
  output tcc_pkg::tcc_pins_t pins
);
  initial pins = '{countInputPin: 1'b1, reloadPin: 1'b1, captureInputPin: 4'h0};
  // four clocks per level keeps edges well under half the clock rate
  task automatic hold();
    repeat (4) @(posedge clock);
  endtask
  task automatic cnt(input int n);
    repeat (n) begin
      pins.countInputPin <= 1'b0;
      hold();
      pins.countInputPin <= 1'b1;
      hold();
    end
  endtask
  task automatic level(input logic v);
    pins.countInputPin <= v;
    hold();
  endtask
  task automatic rl();
    pins.reloadPin <= 1'b0;
    hold();
    pins.reloadPin <= 1'b1;
    hold();
  endtask
  task automatic capSet(input int i, input logic v);
    pins.captureInputPin[i] <= v;
    hold();
  endtask
  task automatic cap(input int i);
    capSet(i, 1'b1);
    capSet(i, 1'b0);
  endtask
endmodule

// file: sim/tb.sv
// self-checking bench for the timer capture/compare unit
// apb master tasks, pin model partner, checker bound below
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wv;
    logic [7:0] ex;
    logic err;
  } tcc_row_t;
  logic clock, reset_n, psel, penable, pwrite, pready, pslverr, timerIrq, errv;
  logic [tcc_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] cmpOut, cmpOe;
  logic [1:0] lowBits;
  tcc_pkg::tcc_pins_t pins;
  int nMismatch, totalChecks;
  tcc_row_t rows [18] = '{
    '{8'hc8, 8'hfc, 8'hfc, 1'b0}, '{8'hc1, 8'hff, 8'hff, 1'b0}, '{8'hcd, 8'h5a, 8'h5a, 1'b0},
    '{8'hcc, 8'ha5, 8'ha5, 1'b0}, '{8'hca, 8'h12, 8'h12, 1'b0}, '{8'hcb, 8'h34, 8'h34, 1'b0},
    '{8'hc2, 8'h56, 8'h56, 1'b0}, '{8'hc3, 8'h78, 8'h78, 1'b0}, '{8'hc4, 8'h9a, 8'h9a, 1'b0},
    '{8'hc5, 8'hbc, 8'hbc, 1'b0}, '{8'hc6, 8'hde, 8'hde, 1'b0}, '{8'hc7, 8'hf1, 8'hf1, 1'b0},
    '{8'ha8, 8'ha0, 8'ha0, 1'b0}, '{8'hb8, 8'hbc, 8'hbc, 1'b0}, '{8'hc0, 8'hfc, 8'hfc, 1'b0},
    '{8'hc9, 8'h0f, 8'h0f, 1'b0}, '{8'h00, 8'hff, 8'h00, 1'b1}, '{8'hd0, 8'hff, 8'h00, 1'b1}};
  tcc_timer_unit dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinsIn(pins), .compareOut(cmpOut), .compareOutEnable(cmpOe),
    .timerIrq(timerIrq));
  tcc_pin_model pm (.clock(clock), .pins(pins));
  task automatic chkVal(input string nm, input logic [31:0] ex, input logic [31:0] got);
    totalChecks++;
    if (got !== ex) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // tick phase of the divider is unknown, so one tick less is accepted
  task automatic chkNear(input string nm, input logic [31:0] ex, input logic [31:0] got);
    totalChecks++;
    if (got !== ex && got !== ex - 32'h1) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, lowBits};
    // upper lanes carry copies; the block must ignore them
    pwdata <= {4{d}};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (k >= 100) nMismatch++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] ex);
    apb(idx, 1'b0, 8'h00);
    chkVal(nm, {24'h0, ex}, rdv);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic setCnt(input logic [15:0] v);
    wr(8'hcd, v[15:8]);
    wr(8'hcc, v[7:0]);
  endtask
  task automatic rdCnt(input logic [15:0] ex);
    rd("count lo", 8'hcc, ex[7:0]);
    rd("count hi", 8'hcd, ex[15:8]);
  endtask
  task automatic pinChk(input string nm, input logic [3:0] ex);
    chkVal(nm, {28'h0, ex}, {28'h0, cmpOut});
  endtask
  task automatic rate(input logic [7:0] ctl, input logic [7:0] ex);
    setCnt(16'h0000);
    wr(8'hc8, ctl);
    idle(240);
    wr(8'hc8, 8'h00);
    apb(8'hcc, 1'b0, 8'h00);
    chkNear("rate", {24'h0, ex}, rdv);
  endtask
  task automatic closeOut();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    repeat (30000) @(posedge clock);
    nMismatch++;
    closeOut();
  end
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, lowBits} = '0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    foreach (rows[j]) begin
      rd("reset value", rows[j].idx, 8'h00);
      wr(rows[j].idx, rows[j].wv);
      chkVal("error flag", {31'h0, rows[j].err}, {31'h0, errv});
      rd("readback", rows[j].idx, rows[j].ex);
      wr(rows[j].idx, 8'h00);
    end
    lowBits = 2'b10;
    wr(8'hc9, 8'h0f);
    chkVal("misaligned error", 32'h1, {31'h0, errv});
    lowBits = 2'b00;
    rd("misaligned ignored", 8'hc9, 8'h00);
    rdCnt(16'h0000);
    rate(8'h01, 8'(240 / tcc_pkg::DIV_12 + 1));
    rate(8'h81, 8'(240 / tcc_pkg::DIV_24 + 1));
    pm.level(1'b0);
    setCnt(16'h0000);
    wr(8'hc8, 8'h03);
    idle(240);
    rdCnt(16'h0000);
    pm.level(1'b1);
    idle(236);
    wr(8'hc8, 8'h00);
    apb(8'hcc, 1'b0, 8'h00);
    chkNear("gated rate", 32'd20, rdv);
    setCnt(16'h0000);
    wr(8'hc8, 8'h02);
    pm.cnt(5);
    rdCnt(16'h0005);
    wr(8'hca, 8'hf0);
    wr(8'hcb, 8'hff);
    setCnt(16'hfffe);
    wr(8'hc8, 8'h12);
    wr(8'ha8, 8'ha0);
    pm.cnt(3);
    rdCnt(16'hfff1);
    rd("flags", 8'hc0, 8'h40);
    chkVal("irq", 32'h1, {31'h0, timerIrq});
    wr(8'ha8, 8'h80);
    idle(3);
    chkVal("irq masked", 32'h0, {31'h0, timerIrq});
    wr(8'hc0, 8'h00);
    rd("flag clear", 8'hc0, 8'h00);
    wr(8'hc8, 8'h1a);
    setCnt(16'h0100);
    wr(8'hca, 8'h34);
    wr(8'hcb, 8'h12);
    wr(8'hb8, 8'h80);
    wr(8'ha8, 8'ha0);
    pm.rl();
    rdCnt(16'h1234);
    rd("reload flag", 8'hc0, 8'h80);
    chkVal("reload irq", 32'h1, {31'h0, timerIrq});
    pm.cnt(1);
    rdCnt(16'h1235);
    wr(8'hc0, 8'h00);
    wr(8'hb8, 8'h00);
    pm.rl();
    rd("reload flag off", 8'hc0, 8'h00);
    wr(8'hc8, 8'h02);
    wr(8'hc1, 8'h08);
    wr(8'hc2, 8'h10);
    wr(8'hc3, 8'h00);
    setCnt(16'h000e);
    wr(8'hb8, 8'h08);
    pm.cnt(1);
    pinChk("below compare", 4'b0000);
    pm.cnt(1);
    pinChk("at compare", 4'b0010);
    rd("compare flag", 8'hc0, 8'h08);
    chkVal("compare irq", 32'h1, {31'h0, timerIrq});
    wr(8'hb8, 8'h00);
    idle(3);
    chkVal("compare irq off", 32'h0, {31'h0, timerIrq});
    wr(8'hc8, 8'h06);
    wr(8'hc9, 8'h00);
    setCnt(16'h000f);
    pm.cnt(1);
    pinChk("indirect low", 4'b0000);
    wr(8'hc9, 8'h02);
    setCnt(16'h000f);
    pm.cnt(1);
    pinChk("indirect high", 4'b0010);
    setCnt(16'hffff);
    pm.cnt(1);
    pinChk("overflow hold", 4'b0010);
    wr(8'hc0, 8'h00);
    wr(8'hc8, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(8'hc1, 8'h01 << (2 * i));
      setCnt(16'h0a20 + 16'(i));
      pm.cap(i);
      rd("capture lo", tcc_pkg::CC_LO_IDX[8*i +: 8], 8'h20 + 8'(i));
      rd("capture hi", tcc_pkg::CC_HI_IDX[8*i +: 8], 8'h0a);
      chkVal("pin owner", 32'h1 << i, {28'h0, cmpOe});
    end
    wr(8'hc1, 8'hc0);
    setCnt(16'h3344);
    wr(8'hc6, 8'hff);
    rd("write capture lo", 8'hc6, 8'h44);
    rd("write capture hi", 8'hc7, 8'h33);
    wr(8'hc8, 8'h02);
    wr(8'hc1, 8'h02);
    wr(8'hcb, 8'h00);
    setCnt(16'h001f);
    pm.cnt(1);
    rd("unequal event at match", 8'hc0, 8'h00);
    pinChk("module0 at compare", 4'b0001);
    pm.cnt(1);
    rd("unequal event after", 8'hc0, 8'h04);
    wr(8'hc8, 8'h00);
    wr(8'hc1, 8'h01);
    pm.capSet(0, 1'b1);
    setCnt(16'h0b0c);
    pm.capSet(0, 1'b0);
    rd("falling capture lo", 8'hca, 8'h0c);
    rd("falling capture hi", 8'hcb, 8'h0b);
    reset_n <= 1'b0;
    idle(3);
    chkVal("owner in reset", 32'h0, {28'h0, cmpOe});
    reset_n <= 1'b1;
    idle(1);
    rd("function after reset", 8'hc1, 8'h00);
    closeOut();
  end
endmodule
bind tcc_timer_unit tcc_timer_unit_properties props (.clock(clock), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .compareOut(compareOut),
  .compareOutEnable(compareOutEnable), .timerIrq(timerIrq));
